// ===== pkg/io_accumulator_arith_command_pkg.sv
// constants, types and helpers for the i/o bank and accumulator commands
// assumes one synchronous clock domain and byte-wide command frames
package io_accumulator_arith_command_pkg;

  // ****************************************
  // frame layout and codes
  // ****************************************
  typedef logic [7:0] byte_t;
  localparam int FRAME_BYTES = 9;
  localparam int FRAME_LAST = FRAME_BYTES - 1;
  typedef byte_t [FRAME_BYTES-1:0] frame_t;
  typedef logic [3:0] cnt_t;

  localparam int POS_ADDR = 0;
  localparam int POS_INSTR = 1;
  localparam int POS_TYPE = 2;
  localparam int POS_BANK = 3;
  localparam int POS_VAL3 = 4;
  localparam int POS_VAL2 = 5;
  localparam int POS_VAL1 = 6;
  localparam int POS_VAL0 = 7;
  localparam int POS_CSUM = 8;
  localparam int POS_STATUS = 2;
  localparam int POS_ECHO = 3;

  localparam byte_t INSTR_INPUT_READ = 8'h0F;
  localparam byte_t INSTR_ARITH = 8'h13;
  localparam byte_t INSTR_COMPARE = 8'h14;

  localparam byte_t STATUS_OK = 8'h64;
  localparam byte_t STATUS_BAD_CSUM = 8'h01;
  localparam byte_t STATUS_BAD_CMD = 8'h02;
  localparam byte_t STATUS_BAD_TYPE = 8'h03;
  localparam byte_t STATUS_BAD_VALUE = 8'h04;

  localparam byte_t BANK_DIGITAL = 8'h00;
  localparam byte_t BANK_ANALOG = 8'h01;
  localparam byte_t BANK_OUTPUTS = 8'h02;
  localparam byte_t PORT_ALL = 8'hFF;
  localparam byte_t PORT_ENABLE = 8'h0A;

  typedef enum logic [3:0] {
    ARITH_ADD, ARITH_SUB, ARITH_MUL, ARITH_DIV, ARITH_MOD,
    ARITH_AND, ARITH_OR, ARITH_XOR, ARITH_NOT, ARITH_LOAD
  } arith_e;

  typedef struct packed {
    logic greater;
    logic equal;
    logic less;
  } cmp_flags_s;

  // ****************************************
  // software registers
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ACCUM = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'hC;

  localparam int CTRL_STANDALONE = 0;
  localparam int CTRL_MOD_LSB = 8;
  localparam int CTRL_HOST_LSB = 16;
  localparam byte_t MOD_ADDR_RST = 8'h01;
  localparam byte_t HOST_ADDR_RST = 8'h02;
  localparam int STAT_FLAGS_LSB = 0;
  localparam int STAT_BUSY = 4;
  localparam int STAT_LAST_LSB = 8;
  localparam int COUNT_ERR_LSB = 16;

  // sum of the first eight bytes, wrapping at 256
  function automatic byte_t frame_sum(input frame_t f);
    byte_t s;
    s = 8'h00;
    for (int i = 0; i < FRAME_LAST; i++) begin
      s = s + f[i];
    end
    return s;
  endfunction

endpackage

// ===== pkg/alu_if.sv
// carrier between the command engine and its arithmetic unit
// assumes both ends sit in the same clock domain; the unit is combinational
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
  import io_accumulator_arith_command_pkg::*;
  logic [3:0] op;
  logic signed [31:0] acc;
  logic signed [31:0] operand;
  logic signed [31:0] result;
  cmp_flags_s flags;
  modport ctl (output op, acc, operand, input result, flags);
  modport alu (input op, acc, operand, output result, flags);
endinterface
`default_nettype wire

// ===== rtl/accum_alu.sv
// combinational accumulator arithmetic and signed compare
// assumes the caller registers results; no state in here
`timescale 1ns/100ps
`default_nettype none
module accum_alu (
  alu_if.alu p
);
  import io_accumulator_arith_command_pkg::*;

  // ****************************************
  // arithmetic
  // ****************************************
  logic signed [63:0] prod;

  // full-width divider is long; fine at this rate only with relaxed paths
  always_comb begin
    prod = 64'(p.acc) * 64'(p.operand);
    p.result = p.acc;
    unique case (p.op)
      ARITH_ADD: p.result = p.acc + p.operand;
      ARITH_SUB: p.result = p.acc - p.operand;
      ARITH_MUL: p.result = prod[31:0];
      ARITH_DIV: begin
        // divide by zero leaves the accumulator as it was
        if (p.operand != 32'sh0) begin
          p.result = p.acc / p.operand;
        end
      end
      ARITH_MOD: begin
        if (p.operand != 32'sh0) begin
          p.result = p.acc % p.operand;
        end
      end
      ARITH_AND: p.result = p.acc & p.operand;
      ARITH_OR: p.result = p.acc | p.operand;
      ARITH_XOR: p.result = p.acc ^ p.operand;
      ARITH_NOT: p.result = ~p.acc;
      ARITH_LOAD: p.result = p.operand;
      default: p.result = p.acc;
    endcase
  end

  // ****************************************
  // compare, both sides taken as signed
  // ****************************************
  always_comb begin
    p.flags.greater = p.acc > p.operand;
    p.flags.equal = p.acc == p.operand;
    p.flags.less = p.acc < p.operand;
  end

endmodule
`default_nettype wire

// ===== rtl/io_bank_and_accumulator_commands.sv
// command engine: input bank reads, accumulator arithmetic and compare
// assumes synchronous inputs, a byte stream from a host and a plain
// register port for software
`timescale 1ns/100ps
`default_nettype none

module io_bank_and_accumulator_commands #(
  parameter int NUM_IN = 4,
  parameter int ADC_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [io_accumulator_arith_command_pkg::ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  output logic [7:0] reply_byte_out,
  output logic reply_valid_out,
  input wire logic reply_ready_in,
  input wire logic [NUM_IN-1:0] general_input_line_in,
  input wire logic [NUM_IN-1:0][ADC_W-1:0] adc_result_in,
  input wire logic [NUM_IN-1:0] general_output_line_in,
  input wire logic drive_enable_n_in,
  output io_accumulator_arith_command_pkg::cmp_flags_s flags_out,
  output logic [31:0] accumulator_out
);
  import io_accumulator_arith_command_pkg::*;

  localparam int IDX_W = $clog2(NUM_IN);

  // the line vector must fit in one reply word and stay below port 10
  if (NUM_IN < 2 || NUM_IN > 8) begin : g_bad_lines
    $error("unsupported NUM_IN");
  end
  // the conversion result is returned zero-extended, never sign-extended
  if (ADC_W < 1 || ADC_W > 31) begin : g_bad_adc
    $error("unsupported ADC_W");
  end

  // ****************************************
  // engine state
  // ****************************************
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} state_e;

  state_e state, next_state;
  cnt_t byte_cnt, next_byte_cnt;
  frame_t frame, next_frame;
  frame_t reply, next_reply;
  byte_t reply_byte, next_reply_byte;
  logic signed [31:0] accum, next_accum;
  cmp_flags_s flags, next_flags;
  byte_t last_status, next_last_status;
  logic [15:0] ok_count, next_ok_count;
  logic [15:0] err_count, next_err_count;

  logic [31:0] ctrl, next_ctrl;
  logic [31:0] rdata, next_rdata;

  alu_if alu ();

  accum_alu u_alu (
    .p(alu)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  byte_t instr;
  byte_t port_sel;
  byte_t bank;
  logic signed [31:0] operand;
  logic [IDX_W-1:0] idx;
  logic port_in_range;
  logic standalone;
  byte_t mod_addr;
  byte_t host_addr;

  // one line level widened to a reply word
  function automatic logic [31:0] bit_word(input logic b);
    return {31'h0, b};
  endfunction

  // receive and transmit share the counter; both stop after the checksum
  function automatic logic last_byte(input cnt_t c);
    return c == cnt_t'(FRAME_LAST);
  endfunction

  // a write strobe aimed at one register offset
  function automatic logic write_hit(input logic wr,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] r);
    return wr && a == r;
  endfunction

  assign instr = frame[POS_INSTR];
  assign port_sel = frame[POS_TYPE];
  assign bank = frame[POS_BANK];
  // most significant byte arrives first
  assign operand = {frame[POS_VAL3], frame[POS_VAL2],
                    frame[POS_VAL1], frame[POS_VAL0]};
  assign idx = port_sel[IDX_W-1:0];
  assign port_in_range = port_sel < 8'(NUM_IN);
  assign standalone = ctrl[CTRL_STANDALONE];
  assign mod_addr = ctrl[CTRL_MOD_LSB +: 8];
  assign host_addr = ctrl[CTRL_HOST_LSB +: 8];

  assign alu.op = port_sel[3:0];
  assign alu.acc = accum;
  assign alu.operand = operand;

  // ****************************************
  // command engine
  // ****************************************
  logic [31:0] value;
  byte_t status;
  logic load_acc;

  always_comb begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_frame = frame;
    next_reply = reply;
    next_accum = accum;
    next_flags = flags;
    next_last_status = last_status;
    next_ok_count = ok_count;
    next_err_count = err_count;
    value = 32'h0000_0000;
    status = STATUS_OK;
    load_acc = 1'b0;

    // software may preload the accumulator; a command in the same cycle wins
    if (write_hit(wr_in, addr_in, REG_ACCUM)) begin
      next_accum = wdata_in;
    end

    unique case (state)
      ST_RX: begin
        if (cmd_valid_in) begin
          // bytes arrive in frame order, address first
          next_frame[byte_cnt] = cmd_byte_in;
          if (last_byte(byte_cnt)) begin
            next_byte_cnt = '0;
            next_state = ST_EXEC;
          end else begin
            next_byte_cnt = byte_cnt + 4'h1;
          end
        end
      end
      ST_EXEC: begin
        if (frame[POS_ADDR] != mod_addr) begin
          // frames for other modules are dropped without a reply
          next_state = ST_RX;
        end else begin
          if (frame_sum(frame) != frame[POS_CSUM]) begin
            status = STATUS_BAD_CSUM;
          end else begin
            unique case (instr)
              INSTR_INPUT_READ: begin
                // digital bank reads the input lines, analog the conversion results, outputs the output lines
                unique case (bank)
                  BANK_DIGITAL: begin
                    if (port_in_range) begin
                      value = bit_word(general_input_line_in[idx]);
                      load_acc = standalone;
                    end else if (port_sel == PORT_ALL) begin
                      value = 32'(general_input_line_in);
                      load_acc = 1'b1;
                    end else if (port_sel == PORT_ENABLE) begin
                      value = bit_word(drive_enable_n_in);
                      load_acc = standalone;
                    end else begin
                      status = STATUS_BAD_TYPE;
                    end
                  end
                  BANK_ANALOG: begin
                    if (port_in_range) begin
                      value = 32'(adc_result_in[idx]);
                      load_acc = standalone;
                    end else begin
                      status = STATUS_BAD_TYPE;
                    end
                  end
                  BANK_OUTPUTS: begin
                    if (port_in_range) begin
                      value = bit_word(general_output_line_in[idx]);
                      load_acc = standalone;
                    end else begin
                      status = STATUS_BAD_TYPE;
                    end
                  end
                  default: status = STATUS_BAD_VALUE;
                endcase
                if (load_acc) begin
                  next_accum = value;
                end
              end
              INSTR_ARITH: begin
                if (port_sel > 8'(ARITH_LOAD)) begin
                  status = STATUS_BAD_TYPE;
                end else begin
                  next_accum = alu.result;
                  value = operand;
                end
              end
              INSTR_COMPARE: begin
                // accumulator untouched; flags stay until the next compare
                next_flags = alu.flags;
                value = operand;
              end
              default: status = STATUS_BAD_CMD;
            endcase
          end
          // 16-bit tallies wrap silently; software reads both in one word
          if (status == STATUS_OK) begin
            next_ok_count = ok_count + 16'h0001;
          end else begin
            next_err_count = err_count + 16'h0001;
          end
          next_last_status = status;
          next_reply[POS_ADDR] = host_addr;
          next_reply[POS_INSTR] = mod_addr;
          next_reply[POS_STATUS] = status;
          next_reply[POS_ECHO] = instr;
          next_reply[POS_VAL3] = value[31:24];
          next_reply[POS_VAL2] = value[23:16];
          next_reply[POS_VAL1] = value[15:8];
          next_reply[POS_VAL0] = value[7:0];
          next_reply[POS_CSUM] = frame_sum(next_reply);
          next_state = ST_TX;
        end
      end
      ST_TX: begin
        if (reply_ready_in) begin
          if (last_byte(byte_cnt)) begin
            next_byte_cnt = '0;
            next_state = ST_RX;
          end else begin
            next_byte_cnt = byte_cnt + 4'h1;
          end
        end
      end
    endcase
    // registered so the reply pin comes straight from a flop
    next_reply_byte = next_reply[next_byte_cnt];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_RX;
      byte_cnt <= '0;
      frame <= '0;
      reply <= '0;
      reply_byte <= '0;
      accum <= '0;
      flags <= '0;
      last_status <= STATUS_OK;
      ok_count <= '0;
      err_count <= '0;
    end else begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      frame <= next_frame;
      reply <= next_reply;
      reply_byte <= next_reply_byte;
      accum <= next_accum;
      flags <= next_flags;
      last_status <= next_last_status;
      ok_count <= next_ok_count;
      err_count <= next_err_count;
    end
  end

  // ****************************************
  // software register port
  // ****************************************
  always_comb begin
    next_ctrl = ctrl;
    next_rdata = 32'h0000_0000;
    if (write_hit(wr_in, addr_in, REG_CTRL)) begin
      next_ctrl = 32'h0000_0000;
      next_ctrl[CTRL_STANDALONE] = wdata_in[CTRL_STANDALONE];
      next_ctrl[CTRL_MOD_LSB +: 8] = wdata_in[CTRL_MOD_LSB +: 8];
      next_ctrl[CTRL_HOST_LSB +: 8] = wdata_in[CTRL_HOST_LSB +: 8];
    end
    if (rd_in) begin
      unique case (addr_in)
        REG_CTRL: next_rdata = ctrl;
        REG_ACCUM: next_rdata = accum;
        REG_STATUS: begin
          next_rdata[STAT_FLAGS_LSB +: 3] = flags;
          next_rdata[STAT_BUSY] = state != ST_RX;
          next_rdata[STAT_LAST_LSB +: 8] = last_status;
        end
        REG_COUNT: next_rdata = {err_count, ok_count};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= {8'h00, HOST_ADDR_RST, MOD_ADDR_RST, 8'h00};
      rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // receive stalls while a frame executes or its reply drains
  assign cmd_ready_out = state == ST_RX;
  assign reply_valid_out = state == ST_TX;
  assign reply_byte_out = reply_byte;
  assign rdata_out = rdata;
  assign flags_out = flags;
  assign accumulator_out = accum;

endmodule
`default_nettype wire

// ===== verif/io_accumulator_arith_command_checker.sv
// checker: reply framing, hold, flags and accumulator causes
// assumes bind to the command engine top; one clock domain
`timescale 1ns/100ps
`default_nettype none
module io_accumulator_arith_command_checker import io_accumulator_arith_command_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic [7:0] reply_byte_out,
  input wire logic reply_valid_out,
  input wire logic reply_ready_in,
  input wire io_accumulator_arith_command_pkg::cmp_flags_s flags_out,
  input wire logic [31:0] accumulator_out
);
  // ****************************************
  // frame tracking
  // ****************************************
  cnt_t cnt;
  byte_t instr;
  logic addr_ok;
  logic take;
  assign take = cmd_valid_in && cmd_ready_out;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 4'h0;
      instr <= 8'h00;
      addr_ok <= 1'b0;
    end else if (take) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h0) addr_ok <= (cmd_byte_in == MOD_ADDR_RST);
      if (cnt == 4'h1) instr <= cmd_byte_in;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_exec;
    !cmd_ready_out && !reply_valid_out;
  endsequence
  sequence s_host_first;
    reply_valid_out && reply_byte_out == HOST_ADDR_RST;
  endsequence
  a_frame_reply: assert property (take && cnt == 4'h8 && addr_ok |=>
    s_exec ##1 s_host_first) else $error("no reply after frame");
  a_exec_once: assert property (s_exec |=>
    cmd_ready_out || reply_valid_out) else $error("exec too long");
  a_hold_byte: assert property (reply_valid_out && !reply_ready_in |=>
    reply_valid_out && $stable(reply_byte_out)) else $error("reply moved");
  a_no_overlap: assert property (!(cmd_ready_out && reply_valid_out))
    else $error("rx and tx at once");
  a_ready_back: assert property ($fell(reply_valid_out) |->
    cmd_ready_out) else $error("not back to rx");
  a_flags_cmp: assert property (!$stable(flags_out) |->
    $past(instr) == INSTR_COMPARE && !$past(cmd_ready_out))
    else $error("flags moved without compare");
  a_acc_cause: assert property (!$stable(accumulator_out) |->
    $past(wr_in) || !$past(cmd_ready_out || reply_valid_out))
    else $error("accumulator moved idle");
  a_status_read: assert property ($past(rd_in) &&
    $past(addr_in) == REG_STATUS |-> rdata_out[2:0] == $past(flags_out))
    else $error("status read wrong");
endmodule
`default_nettype wire

// ===== verif/host_model.sv
// host model: sends nine-byte frames, collects nine-byte replies
// assumes the caller enters its task just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module host_model import io_accumulator_arith_command_pkg::*; (
  input wire logic clk_in,
  input wire logic cmd_ready_in,
  output logic [7:0] cmd_byte_out,
  output logic cmd_valid_out,
  input wire logic [7:0] reply_byte_in,
  input wire logic reply_valid_in,
  output logic reply_ready_out
);
  initial begin
    cmd_byte_out = 8'h00;
    cmd_valid_out = 1'b0;
    reply_ready_out = 1'b0;
  end
  // slow stalls the reply every other cycle
  task automatic xfer(input frame_t f, input bit slow, input bit want,
                      output frame_t r);
    int i;
    int n;
    r = '0;
    for (i = 0; i < FRAME_BYTES; i++) begin
      cmd_byte_out <= f[i];
      cmd_valid_out <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (!cmd_ready_in && n < 50);
    end
    cmd_valid_out <= 1'b0;
    // released line shows the inverse, not a stale byte
    cmd_byte_out <= ~f[FRAME_LAST];
    i = 0;
    n = 0;
    while (want && i < FRAME_BYTES && n < 60) begin
      reply_ready_out <= !slow || n[0];
      @(posedge clk_in);
      n++;
      if (reply_valid_in && reply_ready_out) begin
        r[i] = reply_byte_in;
        i++;
      end
    end
    reply_ready_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/io_bank_and_accumulator_commands_tb.sv
// testbench: bank reads, accumulator arithmetic, compare, errors
// assumes the host model file and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module io_bank_and_accumulator_commands_tb;
  import io_accumulator_arith_command_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [7:0] cmd_byte_in;
  logic cmd_valid_in;
  logic cmd_ready_out;
  logic [7:0] reply_byte_out;
  logic reply_valid_out;
  logic reply_ready_in;
  logic [3:0] gin = 4'hA;
  logic [3:0][15:0] adc = {16'h8001, 16'h0302, 16'hFFFE, 16'h1234};
  logic [3:0] gout = 4'h6;
  logic en_n = 1'b1;
  cmp_flags_s flags_out;
  logic [31:0] accumulator_out;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2 clk_in = ~clk_in;
  io_bank_and_accumulator_commands u_io_bank_and_accumulator_commands (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cmd_byte_in(cmd_byte_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
    .reply_byte_out(reply_byte_out), .reply_valid_out(reply_valid_out),
    .reply_ready_in(reply_ready_in), .general_input_line_in(gin),
    .adc_result_in(adc), .general_output_line_in(gout),
    .drive_enable_n_in(en_n), .flags_out(flags_out),
    .accumulator_out(accumulator_out));
  host_model u_host_model (.clk_in(clk_in), .cmd_ready_in(cmd_ready_out),
    .cmd_byte_out(cmd_byte_in), .cmd_valid_out(cmd_valid_in),
    .reply_byte_in(reply_byte_out), .reply_valid_in(reply_valid_out),
    .reply_ready_out(reply_ready_in));
  task results;
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  function automatic frame_t mk(byte_t ins, byte_t ty, byte_t bk,
                                logic [31:0] v);
    frame_t f;
    f = {8'h00, v[7:0], v[15:8], v[23:16], v[31:24], bk, ty, ins,
         MOD_ADDR_RST};
    for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
    return f;
  endfunction
  task automatic wr(logic [3:0] a, logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    `CHK(rdata_out, e)
  endtask
  task automatic cmd(byte_t ins, byte_t ty, byte_t bk, logic [31:0] v,
                     byte_t st, logic [31:0] ev, bit slow);
    frame_t r;
    byte_t s;
    u_host_model.xfer(mk(ins, ty, bk, v), slow, 1'b1, r);
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + r[i];
    `CHK(r[0], HOST_ADDR_RST)
    `CHK(r[1], MOD_ADDR_RST)
    `CHK(r[2], st)
    `CHK(r[3], ins)
    `CHK({r[4], r[5], r[6], r[7]}, ev)
    `CHK(r[8], s)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_inputs;
    wr(REG_ACCUM, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      cmd(INSTR_INPUT_READ, 8'(i), BANK_DIGITAL, 0, STATUS_OK,
          {31'h0, gin[i]}, 1'b0);
      cmd(INSTR_INPUT_READ, 8'(i), BANK_ANALOG, 0, STATUS_OK,
          {16'h0, adc[i]}, i[0]);
      cmd(INSTR_INPUT_READ, 8'(i), BANK_OUTPUTS, 0, STATUS_OK,
          {31'h0, gout[i]}, 1'b0);
    end
    cmd(INSTR_INPUT_READ, PORT_ENABLE, BANK_DIGITAL, 0, STATUS_OK, 1, 0);
    en_n <= 1'b0;
    cmd(INSTR_INPUT_READ, PORT_ENABLE, BANK_DIGITAL, 0, STATUS_OK, 0, 0);
    `CHK(accumulator_out, 32'h1234)
    cmd(INSTR_INPUT_READ, PORT_ALL, BANK_DIGITAL, 0, STATUS_OK, 32'hA, 1);
    `CHK(accumulator_out, 32'hA)
  endtask
  task automatic t_arith;
    logic signed [31:0] a;
    logic signed [31:0] e;
    logic signed [31:0] op;
    a = -1234;
    op = -7;
    cmd(INSTR_ARITH, ARITH_LOAD, 0, a, STATUS_OK, a, 1'b0);
    for (int k = 0; k < 9; k++) begin
      case (k)
        0: e = a + op;
        1: e = a - op;
        2: e = a * op;
        3: e = a / op;
        4: e = a % op;
        5: e = a & op;
        6: e = a | op;
        7: e = a ^ op;
        default: e = ~a;
      endcase
      cmd(INSTR_ARITH, 8'(k), 0, op, STATUS_OK, op, k[0]);
      `CHK(accumulator_out, e)
      a = e;
    end
    cmd(INSTR_ARITH, ARITH_DIV, 0, 0, STATUS_OK, 0, 1'b0);
    `CHK(accumulator_out, a)
  endtask
  task automatic t_compare;
    wr(REG_CTRL, 32'h0002_0101);
    cmd(INSTR_ARITH, ARITH_LOAD, 0, -5, STATUS_OK, -5, 1'b0);
    cmd(INSTR_COMPARE, 0, 0, 3, STATUS_OK, 3, 1'b0);
    `CHK(flags_out, 3'b001)
    `CHK(accumulator_out, -5)
    cmd(INSTR_COMPARE, 0, 0, -5, STATUS_OK, -5, 1'b1);
    `CHK(flags_out, 3'b010)
    cmd(INSTR_COMPARE, 0, 0, -9, STATUS_OK, -9, 1'b0);
    `CHK(flags_out, 3'b100)
    cmd(INSTR_INPUT_READ, 0, BANK_ANALOG, 0, STATUS_OK, 32'h1234, 0);
    `CHK(accumulator_out, 32'h1234)
    `CHK(flags_out, 3'b100)
    rd(REG_STATUS, 32'h0000_6404);
    wr(REG_CTRL, 32'h0002_0100);
  endtask
  task automatic t_errors;
    frame_t f;
    frame_t r;
    f = mk(INSTR_ARITH, ARITH_LOAD, 0, 32'h55);
    f[8] = f[8] ^ 8'h01;
    u_host_model.xfer(f, 1'b0, 1'b1, r);
    `CHK(r[2], STATUS_BAD_CSUM)
    `CHK(accumulator_out, 32'h1234)
    f = mk(INSTR_ARITH, ARITH_LOAD, 0, 32'h55);
    f[0] = 8'h07;
    f[8] = f[8] + 8'h06;
    u_host_model.xfer(f, 1'b0, 1'b0, r);
    repeat (20) @(posedge clk_in);
    `CHK(reply_valid_out, 1'b0)
    `CHK(accumulator_out, 32'h1234)
    cmd(8'h0E, 8'h00, 8'h00, 0, STATUS_BAD_CMD, 0, 1'b0);
    cmd(INSTR_INPUT_READ, 8'h00, 8'h03, 0, STATUS_BAD_VALUE, 0, 1'b0);
    cmd(INSTR_ARITH, 8'h0A, 8'h00, 7, STATUS_BAD_TYPE, 0, 1'b1);
    rd(4'h2, 32'h0);
    rd(REG_ACCUM, 32'h1234);
    rd(REG_COUNT, 32'h0004_001F);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(REG_CTRL, 32'h0002_0100);
    `CHK(accumulator_out, 32'h0)
    t_inputs();
    t_arith();
    t_compare();
    t_errors();
    results();
  end
endmodule
bind io_bank_and_accumulator_commands io_accumulator_arith_command_checker u_io_accumulator_arith_command_checker (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .cmd_byte_in(cmd_byte_in),
  .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
  .reply_byte_out(reply_byte_out), .reply_valid_out(reply_valid_out),
  .reply_ready_in(reply_ready_in), .flags_out(flags_out),
  .accumulator_out(accumulator_out));
`default_nettype wire
